//--- rtl/pcih_pkg.sv
// Purpose: constants for the control-input high configuration block
// Assumes: 16-bit register reached over a plain strobe port
// Notes: one writable register plus a read-only status word; offsets chosen locally
package pcih_pkg;
    localparam int unsigned PCIH_NUM_GEN = 4;
    localparam logic [3:0] PCIH_ADDR_CFG_HIGH = 4'h0;
    localparam logic [3:0] PCIH_ADDR_STATUS = 4'h1;
    localparam logic [15:0] PCIH_CFG_RESET = 16'h0000;
    localparam logic [15:0] PCIH_CFG_WMASK = 16'hF7FF;
    localparam int unsigned PCIH_BIT_BYPASS_EN = 15;
    localparam int unsigned PCIH_POS_BYPASS_SEL = 12;
    localparam int unsigned PCIH_POS_ACCEPT = 8;
    localparam int unsigned PCIH_BIT_SW_INPUT = 7;
    localparam int unsigned PCIH_POS_SW_ROUTE = 5;
    localparam int unsigned PCIH_BIT_LATCH_PRIO = 4;
    localparam int unsigned PCIH_BIT_TQ_INVERT = 3;
    localparam int unsigned PCIH_POS_TQ_SOURCE = 0;
    localparam logic [2:0] PCIH_ACP_LEVEL = 3'h0;
    localparam logic [2:0] PCIH_ACP_RISE = 3'h1;
    localparam logic [2:0] PCIH_ACP_ANY = 3'h2;
    localparam logic [2:0] PCIH_ACP_LAT_LEVEL = 3'h3;
    localparam logic [2:0] PCIH_ACP_LAT_RISE = 3'h4;
    localparam logic [2:0] PCIH_ACP_LAT_ANY = 3'h5;
    localparam logic [1:0] PCIH_SWR_ACCEPT = 2'h0;
    localparam logic [1:0] PCIH_SWR_AQUAL = 2'h1;
    localparam logic [1:0] PCIH_SWR_TQUAL = 2'h2;
    localparam logic [2:0] PCIH_TQ_FORCE_HIGH = 3'h0;
    localparam logic [2:0] PCIH_TQ_DUTY = 3'h1;
    localparam logic [2:0] PCIH_TQ_BLANK = 3'h2;
    localparam logic [2:0] PCIH_TQ_TRIG = 3'h3;
    localparam logic [2:0] PCIH_TQ_SHARED = 3'h4;
    localparam logic [2:0] PCIH_TQ_SRC8 = 3'h5;
    localparam logic [2:0] PCIH_TQ_SRC9 = 3'h6;
    localparam logic [2:0] PCIH_TQ_SW_ONLY = 3'h7;
endpackage

//--- rtl/pcih_accept.sv
// Purpose: acceptance criteria evaluation with optional set-reset latch
// Assumes: inputs synchronous to the core clock
// Notes: unlatched edge modes give a one-cycle pulse; latched modes hold until cleared
`timescale 1ns/1ps
`default_nettype none
module pcih_accept (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // control
    input wire logic [2:0] i_mode,
    input wire logic i_reset_dominant,
    input wire logic i_latch_clear,
    // signal
    input wire logic i_sig,
    output logic o_active
);
    import pcih_pkg::*;
    logic prev_q, prev_d;
    logic latch_q, latch_d;
    logic rise, anyedge, set_ev;

    always_comb begin
        rise = i_sig & ~prev_q;
        anyedge = i_sig ^ prev_q;
        prev_d = i_sig;
        unique case (i_mode)
            PCIH_ACP_LAT_LEVEL: set_ev = i_sig;
            PCIH_ACP_LAT_RISE: set_ev = rise;
            PCIH_ACP_LAT_ANY: set_ev = anyedge;
            default: set_ev = 1'b0;
        endcase
        // both together: priority bit decides
        if (set_ev && i_latch_clear) begin
            latch_d = ~i_reset_dominant;
        end else if (set_ev) begin
            latch_d = 1'b1;
        end else if (i_latch_clear) begin
            latch_d = 1'b0;
        end else begin
            latch_d = latch_q;
        end
        unique case (i_mode)
            PCIH_ACP_LEVEL: o_active = i_sig;
            PCIH_ACP_RISE: o_active = rise;
            PCIH_ACP_ANY: o_active = anyedge;
            PCIH_ACP_LAT_LEVEL, PCIH_ACP_LAT_RISE, PCIH_ACP_LAT_ANY: o_active = latch_q;
            default: o_active = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prev_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            latch_q <= latch_d;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pcih_ctrl.sv
// Purpose: upper control half of one generator's control-input path
// Assumes: single clock, synchronous reset, one-cycle register port
// Notes: acceptance output is combinational from the local or bypass path
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pcih_ctrl #(
    parameter int unsigned GEN_PRESENT = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // local path inputs
    input wire logic i_pci_sig,
    input wire logic i_accept_qual,
    input wire logic i_latch_clear,
    // termination qualifier sources
    input wire logic i_duty_active,
    input wire logic i_blank_active,
    input wire logic i_gen_triggered,
    input wire logic i_shared_src,
    input wire logic i_src8,
    input wire logic i_src9,
    // other generators' accepted signals
    input wire logic [pcih_pkg::PCIH_NUM_GEN-1:0] i_peer_accept,
    // results
    output logic o_local_accept,
    output logic o_accept,
    output logic o_accept_qual,
    output logic o_term_qual
);
    import pcih_pkg::*;
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] rdata_q, rdata_d;
    logic bypass_en, sw_input, latch_prio, tq_invert;
    logic [2:0] bypass_sel, accept_mode, tq_src;
    logic [1:0] sw_route;
    logic accept_in, local_acc, peer_sel, tq_raw;

    function automatic logic peer_pick(input logic [2:0] sel, input logic [PCIH_NUM_GEN-1:0] v);
        logic r;
        r = 1'b0;
        // reserved codes and absent generators give zero
        if (sel < 3'(PCIH_NUM_GEN) && sel < 3'(GEN_PRESENT)) begin
            r = v[sel[1:0]];
        end
        return r;
    endfunction

    assign bypass_en = cfg_q[PCIH_BIT_BYPASS_EN];
    assign bypass_sel = cfg_q[PCIH_POS_BYPASS_SEL +: 3];
    assign accept_mode = cfg_q[PCIH_POS_ACCEPT +: 3];
    assign sw_input = cfg_q[PCIH_BIT_SW_INPUT];
    assign sw_route = cfg_q[PCIH_POS_SW_ROUTE +: 2];
    assign latch_prio = cfg_q[PCIH_BIT_LATCH_PRIO];
    assign tq_invert = cfg_q[PCIH_BIT_TQ_INVERT];
    assign tq_src = cfg_q[PCIH_POS_TQ_SOURCE +: 3];

    always_comb begin
        cfg_d = cfg_q;
        if (i_wr && i_addr == PCIH_ADDR_CFG_HIGH) begin
            cfg_d = i_wdata & PCIH_CFG_WMASK;
        end
        rdata_d = 16'h0000;
        if (i_rd) begin
            unique case (i_addr)
                PCIH_ADDR_CFG_HIGH: rdata_d = cfg_q;
                PCIH_ADDR_STATUS: rdata_d = {13'h0, o_term_qual, o_accept_qual, o_accept};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_q <= PCIH_CFG_RESET;
            rdata_q <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end
    assign o_rdata = rdata_q;

    // software bit ored into the routed path
    always_comb begin
        accept_in = i_pci_sig | (sw_input && sw_route == PCIH_SWR_ACCEPT);
        o_accept_qual = i_accept_qual | (sw_input && sw_route == PCIH_SWR_AQUAL);
        unique case (tq_src)
            PCIH_TQ_FORCE_HIGH: tq_raw = 1'b1;
            PCIH_TQ_DUTY: tq_raw = i_duty_active;
            PCIH_TQ_BLANK: tq_raw = i_blank_active;
            PCIH_TQ_TRIG: tq_raw = i_gen_triggered;
            PCIH_TQ_SHARED: tq_raw = i_shared_src;
            PCIH_TQ_SRC8: tq_raw = i_src8;
            PCIH_TQ_SRC9: tq_raw = i_src9;
            PCIH_TQ_SW_ONLY: tq_raw = 1'b0;
        endcase
        // software routing applies after polarity so it stays a forcing term
        o_term_qual = (tq_raw ^ tq_invert) | (sw_input && sw_route == PCIH_SWR_TQUAL);
        peer_sel = peer_pick(bypass_sel, i_peer_accept);
        o_accept = bypass_en ? peer_sel : local_acc;
    end
    assign o_local_accept = local_acc;

    pcih_accept u_accept (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_mode(accept_mode),
        .i_reset_dominant(latch_prio),
        .i_latch_clear(i_latch_clear),
        .i_sig(accept_in),
        .o_active(local_acc)
    );
endmodule
`default_nettype wire

//--- verification/pcih_properties.sv
// Purpose: port checks for pcih_ctrl
// Assumes: one clock, sync reset
// Notes: config mirrored from writes
`timescale 1ns/1ps
`default_nettype none
module pcih_properties import pcih_pkg::*; #(parameter int unsigned GEN_PRESENT = 4) (
    // clock, reset, register port
    input wire logic i_core_clk, input wire logic i_rst, input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata, input wire logic i_wr, input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // signal path
    input wire logic i_pci_sig, input wire logic i_duty_active, input wire logic [3:0] i_peer_accept,
    input wire logic o_local_accept, input wire logic o_accept, input wire logic o_accept_qual,
    input wire logic o_term_qual
);
    logic [15:0] cfg_q, cfg_d;
    always_comb cfg_d = (i_wr && i_addr == PCIH_ADDR_CFG_HIGH) ? i_wdata & PCIH_CFG_WMASK : cfg_q;
    always_ff @(posedge i_core_clk) cfg_q <= i_rst ? PCIH_CFG_RESET : cfg_d;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_rz; !i_rd |=> o_rdata == 16'h0000; endproperty
    a_rz: assert property (p_rz) else $error("rdata not idle");
    property p_rb; i_rd && i_addr == PCIH_ADDR_CFG_HIGH |=> o_rdata == $past(cfg_q); endproperty
    a_rb: assert property (p_rb) else $error("readback");
    property p_byp; cfg_q[15] && !cfg_q[14] && cfg_q[14:12] < GEN_PRESENT |-> o_accept == i_peer_accept[cfg_q[13:12]];
    endproperty
    a_byp: assert property (p_byp) else $error("bypass");
    property p_nop; cfg_q[15] && (cfg_q[14] || cfg_q[14:12] >= GEN_PRESENT) |-> !o_accept; endproperty
    a_nop: assert property (p_nop) else $error("absent source");
    property p_lvl; cfg_q[15:7] == 9'h000 |-> o_accept == i_pci_sig; endproperty
    a_lvl: assert property (p_lvl) else $error("level mode");
    property p_res; cfg_q[10:9] == 2'b11 |-> !o_local_accept; endproperty
    a_res: assert property (p_res) else $error("reserved mode");
    property p_tq; !cfg_q[7] && cfg_q[2:0] == PCIH_TQ_DUTY |-> o_term_qual == (i_duty_active ^ cfg_q[3]); endproperty
    a_tq: assert property (p_tq) else $error("term qualifier");
    property p_aq; cfg_q[7:5] == 3'b101 |-> o_accept_qual; endproperty
    a_aq: assert property (p_aq) else $error("sw qualifier");
endmodule
bind pcih_ctrl pcih_properties #(.GEN_PRESENT(GEN_PRESENT)) chk_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_pci_sig(i_pci_sig), .i_duty_active(i_duty_active), .i_peer_accept(i_peer_accept),
    .o_local_accept(o_local_accept), .o_accept(o_accept), .o_accept_qual(o_accept_qual),
    .o_term_qual(o_term_qual));
`default_nettype wire

//--- verification/pcih_src_model.sv
// Purpose: external control and qualifier sources
// Assumes: levels change only at clock edges
// Notes: one register stage, like a synchronised pin
`timescale 1ns/1ps
`default_nettype none
module pcih_src_model (
    // clock
    input wire logic i_core_clk,
    // commanded and driven levels
    input wire logic [12:0] i_cmd,
    output logic [12:0] o_lines
);
    initial o_lines = 13'h0000;
    always @(posedge i_core_clk) o_lines <= i_cmd;
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: self-checking bench for pcih_ctrl
// Assumes: three of four generators' peers present
// Notes: GEN_PRESENT 3 exercises an absent source
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, wr = 0, rd = 0;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [12:0] cmd = '0;
    wire logic [12:0] ln;
    wire logic [15:0] rdata;
    wire logic la, acc, aq, tq;
    int miscompares = 0, n_tests = 0, cyc = 0;
    always #2.5 clk = ~clk;
    pcih_src_model src_u (.i_core_clk(clk), .i_cmd(cmd), .o_lines(ln));
    pcih_ctrl #(.GEN_PRESENT(3)) dut_u (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pci_sig(ln[0]), .i_accept_qual(ln[1]),
        .i_latch_clear(ln[2]), .i_duty_active(ln[3]), .i_blank_active(ln[4]), .i_gen_triggered(ln[5]),
        .i_shared_src(ln[6]), .i_src8(ln[7]), .i_src9(ln[8]), .i_peer_accept(ln[12:9]),
        .o_local_accept(la), .o_accept(acc), .o_accept_qual(aq), .o_term_qual(tq));
    task cmp(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task wrt(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
        #1;
    endtask
    task rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 cmp("rdata", rdata, e);
    endtask
    // the source model adds one edge
    task stp(input logic [12:0] c);
        @(posedge clk) cmd <= c;
        @(posedge clk) #1;
    endtask
    task t_regs;
        rdc(0, 16'h0000);
        wrt(0, 16'hFFFF);
        rdc(0, 16'hF7FF);
        wrt(5, 16'h1234);
        rdc(5, 16'h0000);
        // mid-run reset must bring the written config back to zero
        @(posedge clk) rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rdc(0, 16'h0000);
        $display("regs done");
    endtask
    task t_acc;
        for (int c = 0; c < 8; c++) begin
            wrt(0, 16'(c << 8));
            stp(13'h0004);
            stp(13'h0000);
            stp(13'h0001);
            cmp("acc", 16'(la), 16'((8'h07 >> c) & 1));
            @(posedge clk) #1 cmp("acc next", 16'(la), 16'((8'h39 >> c) & 1));
        end
        for (int p = 0; p < 2; p++) begin
            wrt(0, 16'(16'h0400 | (p << 4)));
            stp(13'h0004);
            stp(13'h0005);
            @(posedge clk) #1 cmp("latch", 16'(la), 16'(p == 0));
        end
        $display("accept done");
    endtask
    task t_sw;
        stp(13'h0000);
        for (int r = 0; r < 4; r++) begin
            wrt(0, 16'(16'h0087 | (r << 5)));
            cmp("sw acc", 16'(acc), 16'(r == 0));
            cmp("sw aq", 16'(aq), 16'(r == 1));
            cmp("sw tq", 16'(tq), 16'(r == 2));
            rdc(1, 16'({r == 2, r == 1, r == 0}));
        end
        wrt(0, 16'h0007);
        cmp("sw off", 16'(acc), 16'h0000);
        $display("software done");
    endtask
    task t_tq;
        stp(13'h00A8);
        for (int i = 0; i < 16; i++) begin
            wrt(0, 16'(i));
            cmp("tq", 16'(tq), 16'(((8'h2B >> i[2:0]) & 1) ^ i[3]));
        end
        $display("qualifier done");
    endtask
    task t_byp;
        stp(13'h1400);
        for (int c = 0; c < 8; c++) begin
            wrt(0, 16'(16'h8000 | (c << 12)));
            cmp("bypass", 16'(acc), 16'(c < 3 && ((4'hA >> c) & 1)));
        end
        wrt(0, 16'h1000);
        cmp("own path", 16'(acc), 16'h0000);
        $display("bypass done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        t_regs;
        t_acc;
        t_sw;
        t_tq;
        t_byp;
        end_of_test;
    end
endmodule
`default_nettype wire
